// [hw/gpio_mux_pkg.sv]
/*
 * Constants, register map and carrier types of the pin mux / GPIO port.
 * Assumes 16-bit word addressing on the CPU peripheral bus.
 */
package gpio_mux_pkg;
    // ==========================================================
    // sizes and pin map
    localparam int NPIN = 39;
    localparam int NAIO = 16;
    localparam int NCFG = 17;
    // implemented pins: A 0-7,12,16-19,28,29 and B 32-38
    localparam logic [38:0] PIN_IMPL = 39'h7F_300F_10FF;
    localparam int PIN_TDI = 35;
    localparam int PIN_TMS = 36;
    localparam int PIN_TDO = 37;
    localparam int PIN_TCK = 38;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [1:0] FSEL_GPIO = 2'b00;
    localparam logic [1:0] QS_3 = 2'b01;
    localparam logic [1:0] QS_6 = 2'b10;
    // ==========================================================
    // word addresses
    localparam logic [15:0] ADR_ACTRL = 16'h6F80;
    localparam logic [15:0] ADR_AQS1 = 16'h6F82;
    localparam logic [15:0] ADR_AQS2 = 16'h6F84;
    localparam logic [15:0] ADR_AMX1 = 16'h6F86;
    localparam logic [15:0] ADR_AMX2 = 16'h6F88;
    localparam logic [15:0] ADR_ADIR = 16'h6F8A;
    localparam logic [15:0] ADR_APUD = 16'h6F8C;
    localparam logic [15:0] ADR_BCTRL = 16'h6F90;
    localparam logic [15:0] ADR_BQS = 16'h6F92;
    localparam logic [15:0] ADR_BMX = 16'h6F96;
    localparam logic [15:0] ADR_BDIR = 16'h6F9A;
    localparam logic [15:0] ADR_BPUD = 16'h6F9C;
    localparam logic [15:0] ADR_IOMX = 16'h6FB6;
    localparam logic [15:0] ADR_IODIR = 16'h6FBA;
    localparam logic [15:0] ADR_ADAT = 16'h6FC0;
    localparam logic [15:0] ADR_ASET = 16'h6FC2;
    localparam logic [15:0] ADR_ACLR = 16'h6FC4;
    localparam logic [15:0] ADR_ATGL = 16'h6FC6;
    localparam logic [15:0] ADR_BDAT = 16'h6FC8;
    localparam logic [15:0] ADR_BSET = 16'h6FCA;
    localparam logic [15:0] ADR_BCLR = 16'h6FCC;
    localparam logic [15:0] ADR_BTGL = 16'h6FCE;
    localparam logic [15:0] ADR_IODAT = 16'h6FD8;
    localparam logic [15:0] ADR_IOSET = 16'h6FDA;
    localparam logic [15:0] ADR_IOCLR = 16'h6FDC;
    localparam logic [15:0] ADR_IOTGL = 16'h6FDE;
    localparam logic [15:0] ADR_XI12 = 16'h6FE0;
    localparam logic [15:0] ADR_XI3 = 16'h6FE2;
    localparam logic [15:0] ADR_LPM = 16'h6FE8;
    // ==========================================================
    // writable bits of narrow registers
    localparam logic [31:0] MSK_BCTRL = 32'h0000_00FF;
    localparam logic [31:0] MSK_B2 = 32'h0000_3FFF;
    localparam logic [31:0] MSK_B1 = 32'h0000_007F;
    localparam logic [31:0] MSK_IO = 32'h0000_FFFF;
    localparam logic [31:0] MSK_XI = 32'h001F_001F;
    localparam logic [31:0] MSK_XI3 = 32'h0000_001F;
    // ==========================================================
    // register slots; the first NCFG are protected config words
    typedef enum logic [4:0] {
        S_ACTRL, S_AQS1, S_AQS2, S_AMX1, S_AMX2, S_ADIR, S_APUD,
        S_BCTRL, S_BQS, S_BMX, S_BDIR, S_BPUD, S_IOMX, S_IODIR,
        S_XI12, S_XI3, S_LPM,
        S_ADAT, S_ASET, S_ACLR, S_ATGL, S_BDAT, S_BSET, S_BCLR,
        S_BTGL, S_IODAT, S_IOSET, S_IOCLR, S_IOTGL, S_NONE
    } slot_e;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        wide;
        logic [15:0] addr;
        logic [31:0] wdata;
    } bus_req_s;
    typedef struct packed {
        logic [38:0] out;
        logic [38:0] oe;
        logic [38:0] pud;
    } pad_s;
    typedef struct packed {
        logic [15:0] out;
        logic [15:0] oe;
        logic [15:0] ana;
    } aio_s;
    typedef struct packed {
        logic [2:0][38:0] out;
        logic [2:0][38:0] oe;
    } periph_s;
    typedef struct packed {
        logic tck;
        logic tdi;
        logic tms;
    } dbg_s;
endpackage

// [hw/gpio_pin_mux_port.sv]
/*
 * Pin multiplexer and GPIO port: registers, qualification, pad drive.
 * Assumes a single-cycle CPU bus request and pads resolved outside.
 */
`timescale 1ns/1ps
// Notes on behaviour
// R1: each pin picks GPIO or one of three peripheral signals.
// R2: twenty-two pins over port A, port B and analog group; the code has all 22 in ports A and B, plus 16 analog group pins.
// R3: every register takes 32-bit and 16-bit accesses.
// R4: function and qualifier select changes reach the pin two cycles after write.
// R5: control registers ignore writes without protected write enable.
// R6: three interrupt pin selects and one low-power select, all protected.
// R7: low-power select bit per port A pin joins wake function.
// R8: test reset chooses debug or GPIO use of four shared pins.
// R9: in debug use the debug port owns the shared pins.
// R10: clock, data-in, mode and data-out pins double as GPIO.
// R11: port A has data, set, clear, toggle registers.
// R12: port B has full control and data register set.
// R13: analog group has mux, direction, data, set, clear, toggle.
// R14: port A qualification split low and high halves.
// R15: pull-up disable bit per port A pin.
// R16: direction bit per pin chooses output drive or input only.
// R17: two-bit function field, 00 at reset is GPIO.
// R18: software avoids reserved function codes.
// R19: set, clear, toggle act on ones only and read zero.
// R20: data read gives qualified pin level, write loads latches; analog group data reads give the synchronised, unqualified level.
module gpio_pin_mux_port
    import gpio_mux_pkg::*;
(
    input  wire logic                  ref_clk_i,
    input  wire logic                  sys_rst_i,
    input  wire gpio_mux_pkg::bus_req_s bus_i,
    input  wire logic                  pwe_i,
    output logic [31:0]                rdata_o,
    input  wire logic [38:0]           pad_in_i,
    output gpio_mux_pkg::pad_s         pad_o,
    input  wire logic [15:0]           aio_in_i,
    output gpio_mux_pkg::aio_s         aio_o,
    input  wire gpio_mux_pkg::periph_s periph_i,
    output logic [38:0]                periph_in_o,
    input  wire logic                  trst_i,
    input  wire logic                  tdo_i,
    input  wire logic                  tdo_oe_i,
    output gpio_mux_pkg::dbg_s         dbg_o,
    output logic [2:0]                 ext_irq_o,
    output logic                       lpm_wake_o
);
    import gpio_mux_pkg::*;

    // ==========================================================
    // address decode
    function automatic slot_e dec(input logic [15:0] a);
        case ({a[15:1], 1'b0})
            ADR_ACTRL: dec = S_ACTRL;
            ADR_AQS1:  dec = S_AQS1;
            ADR_AQS2:  dec = S_AQS2;
            ADR_AMX1:  dec = S_AMX1;
            ADR_AMX2:  dec = S_AMX2;
            ADR_ADIR:  dec = S_ADIR;
            ADR_APUD:  dec = S_APUD;
            ADR_BCTRL: dec = S_BCTRL;
            ADR_BQS:   dec = S_BQS;
            ADR_BMX:   dec = S_BMX;
            ADR_BDIR:  dec = S_BDIR;
            ADR_BPUD:  dec = S_BPUD;
            ADR_IOMX:  dec = S_IOMX;
            ADR_IODIR: dec = S_IODIR;
            ADR_XI12:  dec = S_XI12;
            ADR_XI3:   dec = S_XI3;
            ADR_LPM:   dec = S_LPM;
            ADR_ADAT:  dec = S_ADAT;
            ADR_ASET:  dec = S_ASET;
            ADR_ACLR:  dec = S_ACLR;
            ADR_ATGL:  dec = S_ATGL;
            ADR_BDAT:  dec = S_BDAT;
            ADR_BSET:  dec = S_BSET;
            ADR_BCLR:  dec = S_BCLR;
            ADR_BTGL:  dec = S_BTGL;
            ADR_IODAT: dec = S_IODAT;
            ADR_IOSET: dec = S_IOSET;
            ADR_IOCLR: dec = S_IOCLR;
            ADR_IOTGL: dec = S_IOTGL;
            default:   dec = S_NONE;
        endcase
    endfunction

    function automatic logic [31:0] wmsk(input slot_e s);
        case (s)
            S_BCTRL:                wmsk = MSK_BCTRL;
            S_BQS, S_BMX:           wmsk = MSK_B2;
            S_BDIR, S_BPUD:         wmsk = MSK_B1;
            S_IODIR:                wmsk = MSK_IO;
            S_XI12:                 wmsk = MSK_XI;
            S_XI3:                  wmsk = MSK_XI3;
            default:                wmsk = ~CFG_RST;
        endcase
    endfunction

    slot_e       slot;
    logic [31:0] wd;
    logic [31:0] m;
    logic [31:0] cfg_q [NCFG];
    logic [38:0] lat_q;
    logic [15:0] io_lat_q;
    logic [38:0] qual_q;
    logic [15:0] io_in;

    assign slot = dec(bus_i.addr);
    // R3: 16-bit access lands in the lane picked by the odd address bit
    assign wd = bus_i.wide ? bus_i.wdata : {2{bus_i.wdata[15:0]}};
    assign m = bus_i.wide ? 32'hFFFF_FFFF
             : bus_i.addr[0] ? 32'hFFFF_0000 : 32'h0000_FFFF;

    // ==========================================================
    // protected configuration words
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            for (int k = 0; k < NCFG; k++)
                cfg_q[k] <= CFG_RST;
        end
        // R5: config writes need protected write enable
        else if (bus_i.wr && pwe_i && slot < S_ADAT)
        begin
            cfg_q[slot] <= (cfg_q[slot] & ~m) | (wd & m & wmsk(slot));
        end
    end

    // ==========================================================
    // output latches
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            lat_q    <= '0;
            io_lat_q <= '0;
        end
        else if (bus_i.wr)
        begin
            // R11: port A data operations
            // R19: only ones act in set, clear and toggle
            case (slot)
                S_ADAT:  lat_q[31:0] <= (lat_q[31:0] & ~m) | (wd & m);
                S_ASET:  lat_q[31:0] <= lat_q[31:0] | (wd & m);
                S_ACLR:  lat_q[31:0] <= lat_q[31:0] & ~(wd & m);
                S_ATGL:  lat_q[31:0] <= lat_q[31:0] ^ (wd & m);
                // R12: port B data operations
                S_BDAT:  lat_q[38:32] <= (lat_q[38:32] & ~m[6:0]) | (wd[6:0] & m[6:0]);
                S_BSET:  lat_q[38:32] <= lat_q[38:32] | (wd[6:0] & m[6:0]);
                S_BCLR:  lat_q[38:32] <= lat_q[38:32] & ~(wd[6:0] & m[6:0]);
                S_BTGL:  lat_q[38:32] <= lat_q[38:32] ^ (wd[6:0] & m[6:0]);
                // R13: analog group data operations
                S_IODAT: io_lat_q <= (io_lat_q & ~m[15:0]) | (wd[15:0] & m[15:0]);
                S_IOSET: io_lat_q <= io_lat_q | (wd[15:0] & m[15:0]);
                S_IOCLR: io_lat_q <= io_lat_q & ~(wd[15:0] & m[15:0]);
                S_IOTGL: io_lat_q <= io_lat_q ^ (wd[15:0] & m[15:0]);
                default: lat_q <= lat_q;
            endcase
        end
    end

    // ==========================================================
    // read port, answer one cycle after the request
    logic [31:0] rfull;
    always_comb
    begin
        rfull = '0;
        if (slot < S_ADAT)
            rfull = cfg_q[slot];
        else
        begin
            // R20: port A and B data reads show qualified pin levels, analog group data reads the synchronised level
            case (slot)
                S_ADAT:  rfull = qual_q[31:0];
                S_BDAT:  rfull = {25'h0, qual_q[38:32]};
                S_IODAT: rfull = {16'h0, io_in};
                default: rfull = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            rdata_o <= '0;
        else if (bus_i.rd)
            rdata_o <= bus_i.wide ? rfull
                     : bus_i.addr[0] ? {16'h0, rfull[31:16]} : {16'h0, rfull[15:0]};
    end

    // ==========================================================
    // delayed select copies
    logic [38:0][1:0] fsel_q;
    logic [38:0][1:0] qsel_q;
    logic [31:0]      iomx_q;
    // R4: one staging flop plus the pad flop gives two cycles
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            fsel_q <= '0;
            qsel_q <= '0;
            iomx_q <= '0;
        end
        else
        begin
            fsel_q <= {cfg_q[S_BMX][13:0], cfg_q[S_AMX2], cfg_q[S_AMX1]};
            // R14: low half from first select, high half from second
            qsel_q <= {cfg_q[S_BQS][13:0], cfg_q[S_AQS2], cfg_q[S_AQS1]};
            iomx_q <= cfg_q[S_IOMX];
        end
    end

    // ==========================================================
    // synchronisers
    logic [38:0] sy1_q;
    logic [38:0] sy2_q;
    logic [15:0] io1_q;
    logic [15:0] io2_q;
    logic [1:0]  trst_q;
    logic        dbg;
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            sy1_q  <= '0;
            sy2_q  <= '0;
            io1_q  <= '0;
            io2_q  <= '0;
            trst_q <= '0;
        end
        else
        begin
            sy1_q  <= pad_in_i;
            sy2_q  <= sy1_q;
            io1_q  <= aio_in_i;
            io2_q  <= io1_q;
            trst_q <= {trst_q[0], trst_i};
        end
    end
    assign io_in = io2_q;
    // R8: test reset high selects debug use
    assign dbg = trst_q[1];

    // ==========================================================
    // qualification sample clocks, one per group of eight pins
    logic [4:0]  samp;
    logic [38:0] dir;
    logic [38:0] po;
    logic [38:0] poe;
    // R16: direction bits; R12: port B direction
    assign dir = {cfg_q[S_BDIR][6:0], cfg_q[S_ADIR]};
    genvar g;
    generate
        for (g = 0; g < 5; g++)
        begin : grp
            logic [8:0] cnt_q;
            logic [7:0] prd;
            assign prd = (g < 4) ? cfg_q[S_ACTRL][8*(g%4) +: 8] : cfg_q[S_BCTRL][7:0];
            // period is twice the control byte, zero samples every cycle
            assign samp[g] = ({1'b0, cnt_q} + 10'd1) >= {1'b0, prd, 1'b0};
            always_ff @(posedge ref_clk_i)
            begin
                if (sys_rst_i || samp[g])
                    cnt_q <= '0;
                else
                    cnt_q <= cnt_q + 9'd1;
            end
        end
    endgenerate

    // ==========================================================
    // per-pin qualification and output select
    genvar i;
    generate
        for (i = 0; i < NPIN; i++)
        begin : pin
            logic [5:0] hist_q;
            always_ff @(posedge ref_clk_i)
            begin
                if (sys_rst_i)
                begin
                    hist_q    <= '0;
                    qual_q[i] <= 1'b0;
                end
                else
                begin
                    if (samp[i/8])
                        hist_q <= {hist_q[4:0], sy2_q[i]};
                    case (qsel_q[i])
                        QS_3:
                        begin
                            if (&hist_q[2:0])
                                qual_q[i] <= 1'b1;
                            else if (~|hist_q[2:0])
                                qual_q[i] <= 1'b0;
                        end
                        QS_6:
                        begin
                            if (&hist_q)
                                qual_q[i] <= 1'b1;
                            else if (~|hist_q)
                                qual_q[i] <= 1'b0;
                        end
                        default: qual_q[i] <= sy2_q[i];
                    endcase
                end
            end

            always_comb
            begin
                po[i]  = 1'b0;
                poe[i] = 1'b0;
                // R2: unimplemented positions stay undriven
                if (!PIN_IMPL[i])
                    poe[i] = 1'b0;
                // R9: debug port owns the shared pins
                else if (dbg && i >= PIN_TDI)
                begin
                    po[i]  = (i == PIN_TDO) ? tdo_i : 1'b0;
                    poe[i] = (i == PIN_TDO) ? tdo_oe_i : 1'b0;
                end
                else
                begin
                    // R1: GPIO or one of three peripheral signals
                    // R17: code 00 is GPIO
                    case (fsel_q[i])
                        FSEL_GPIO:
                        begin
                            po[i]  = lat_q[i];
                            poe[i] = dir[i];
                        end
                        2'b01:
                        begin
                            po[i]  = periph_i.out[0][i];
                            poe[i] = periph_i.oe[0][i];
                        end
                        2'b10:
                        begin
                            po[i]  = periph_i.out[1][i];
                            poe[i] = periph_i.oe[1][i];
                        end
                        default:
                        begin
                            po[i]  = periph_i.out[2][i];
                            poe[i] = periph_i.oe[2][i];
                        end
                    endcase
                end
            end
        end
    endgenerate

    // ==========================================================
    // registered outputs
    logic [15:0] ana;
    generate
        for (i = 0; i < NAIO; i++)
        begin : analog_capable_pin
            // upper bit of each field hands the pin to the analog side
            assign ana[i] = iomx_q[2*i+1];
        end
    endgenerate

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            pad_o       <= '0;
            aio_o       <= '0;
            periph_in_o <= '0;
            dbg_o       <= '0;
        end
        else
        begin
            pad_o.out <= po;
            pad_o.oe  <= poe;
            // R15: pull-up disable per pin
            pad_o.pud <= {cfg_q[S_BPUD][6:0], cfg_q[S_APUD]};
            // R13: analog group drive
            aio_o.out <= io_lat_q;
            aio_o.oe  <= cfg_q[S_IODIR][15:0] & ~ana;
            aio_o.ana <= ana;
            periph_in_o <= qual_q;
            // R10: debug inputs come from shared GPIO pins
            dbg_o.tck <= dbg & sy2_q[PIN_TCK];
            dbg_o.tdi <= dbg & sy2_q[PIN_TDI];
            dbg_o.tms <= dbg & sy2_q[PIN_TMS];
        end
    end

    // R6: interrupt sources and R7: low-power wake on a low pin
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            ext_irq_o  <= '0;
            lpm_wake_o <= 1'b0;
        end
        else
        begin
            ext_irq_o[0] <= qual_q[cfg_q[S_XI12][4:0]];
            ext_irq_o[1] <= qual_q[cfg_q[S_XI12][20:16]];
            ext_irq_o[2] <= qual_q[cfg_q[S_XI3][4:0]];
            lpm_wake_o   <= |(cfg_q[S_LPM] & ~qual_q[31:0]);
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    prot_write_a: assert property ( // R5
        bus_i.wr && !pwe_i && slot == S_ADIR |=> $stable(cfg_q[S_ADIR]))
        else $error("protected register changed without enable");
    mux_delay_a: assert property ( // R4
        bus_i.wr && pwe_i && bus_i.wide && slot == S_AMX1
        |=> ##1 fsel_q[0] == $past(bus_i.wdata[1:0], 2))
        else $error("function select not applied two cycles later");
    half_write_a: assert property ( // R3
        bus_i.wr && pwe_i && !bus_i.wide && bus_i.addr == ADR_ADIR + 16'h0001
        |=> cfg_q[S_ADIR][31:16] == $past(bus_i.wdata[15:0]))
        else $error("16-bit high half write lost");
    set_bit_a: assert property ( // R19
        bus_i.wr && slot == S_ASET && m[0] && bus_i.wdata[0] |=> lat_q[0])
        else $error("set did not set latch");
    toggle_bit_a: assert property ( // R11
        bus_i.wr && slot == S_ATGL && bus_i.wide && bus_i.wdata[0]
        |=> lat_q[0] != $past(lat_q[0]))
        else $error("toggle did not invert latch");
    set_read_a: assert property ( // R19
        bus_i.rd && slot == S_ASET |=> rdata_o == 32'h0000_0000)
        else $error("set register read not zero");
    debug_own_a: assert property ( // R9
        dbg |=> !pad_o.oe[PIN_TDI] && !pad_o.oe[PIN_TCK])
        else $error("debug input pin driven");
    gpio_drive_a: assert property ( // R16
        fsel_q[0] == FSEL_GPIO |=> pad_o.oe[0] == $past(dir[0]))
        else $error("gpio direction not on pad");
    unimpl_pin_a: assert property ( // R2
        !pad_o.oe[8] && !pad_o.oe[31])
        else $error("unimplemented pin driven");
    irq_route_a: assert property ( // R6
        ##1 ext_irq_o[2] == $past(qual_q[cfg_q[S_XI3][4:0]]))
        else $error("interrupt pin select wrong");

    toggle_c: cover property (bus_i.wr && slot == S_ATGL);
    debug_c: cover property ($rose(dbg));
    periph_c: cover property (fsel_q[0] == 2'b01 ##1 pad_o.oe[0]);
    qual6_c: cover property (qsel_q[0] == QS_6 && $changed(qual_q[0]));
endmodule

// [sim/testbench.sv]
/* Self-checking bench for gpio_pin_mux_port: protected registers, set/clear/toggle,
   mux delay, debug pin sharing. Assumes gpio_mux_pkg is compiled first. */
`timescale 1ns/1ps
module testbench;
    import gpio_mux_pkg::*;
    // ==========================================
    // signals
    logic        ref_clk_i, sys_rst_i, pwe_i, trst_i, tdo_i, tdo_oe_i, rd_seen;
    logic [38:0] pad_in_i, periph_in_o;
    logic [15:0] aio_in_i;
    logic [31:0] rdata_o, rnd, val;
    logic [2:0]  ext_irq_o;
    logic        lpm_wake_o;
    bus_req_s    bus_i;
    pad_s        pad_o;
    aio_s        aio_o;
    periph_s     periph_i;
    dbg_s        dbg_o;
    logic [31:0] exp_q[$];
    int          err_total, num_checks, cyc;
    gpio_pin_mux_port uut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i),
        .pwe_i(pwe_i), .rdata_o(rdata_o), .pad_in_i(pad_in_i), .pad_o(pad_o),
        .aio_in_i(aio_in_i), .aio_o(aio_o), .periph_i(periph_i),
        .periph_in_o(periph_in_o), .trst_i(trst_i), .tdo_i(tdo_i),
        .tdo_oe_i(tdo_oe_i), .dbg_o(dbg_o), .ext_irq_o(ext_irq_o),
        .lpm_wake_o(lpm_wake_o));
    // ==========================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
            err_total++;
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    // reads note their expected word; the monitor compares it later
    task automatic access(input logic w, input logic wd, input logic [15:0] a,
                          input logic [31:0] d);
        @(negedge ref_clk_i);
        bus_i <= '{wr: w, rd: !w, wide: wd, addr: a, wdata: d};
        if (!w)
            exp_q.push_back(d);
        @(negedge ref_clk_i);
        bus_i.wr <= 1'b0;
        bus_i.rd <= 1'b0;
    endtask
    task automatic pin_op(input logic [15:0] a, input logic [31:0] d, input logic [2:0] e);
        access(1'b1, 1'b1, a, d);
        idle(1);
        check("pad_out", {29'h0, pad_o.out[2:0]}, {29'h0, e});
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ==========================================
    // clock, monitor, hang guard
    initial
    begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i)
        rd_seen <= bus_i.rd;
    always @(negedge ref_clk_i)
        if (rd_seen === 1'b1)
            check("rdata", rdata_o, exp_q.pop_front());
    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            err_total++;
            complete_run();
        end
    end
    // ==========================================
    // scenarios
    initial
    begin
        {sys_rst_i, pwe_i, trst_i, tdo_i, tdo_oe_i} = 5'b1_0000;
        pad_in_i = '0;
        aio_in_i = '0;
        periph_i = '0;
        bus_i = '0;
        rnd = 32'h18e8;
        idle(8);
        sys_rst_i = 1'b0;
        access(1'b0, 1'b1, ADR_AMX1, 32'h0000_0000);
        $display("reset test done");
        // pwe low must leave the register untouched
        for (int i = 0; i < 2; i++)
        begin
            rnd = lfsr(rnd);
            val = rnd & PIN_IMPL[31:0];
            pwe_i = 1'b0;
            access(1'b1, 1'b1, i ? ADR_LPM : ADR_ADIR, val);
            access(1'b0, 1'b1, i ? ADR_LPM : ADR_ADIR, 32'h0000_0000);
            pwe_i = 1'b1;
            access(1'b1, 1'b1, i ? ADR_LPM : ADR_ADIR, val);
            access(1'b0, 1'b1, i ? ADR_LPM : ADR_ADIR, val);
            access(1'b0, 1'b0, (i ? ADR_LPM : ADR_ADIR) + 16'h0001, {16'h0, val[31:16]});
        end
        $display("protection test done");
        access(1'b1, 1'b0, ADR_ADIR + 16'h0001, 32'h0000_FFFF);
        access(1'b0, 1'b0, ADR_ADIR + 16'h0001, 32'h0000_FFFF);
        access(1'b1, 1'b1, ADR_ADIR, 32'h0000_00FF);
        pin_op(ADR_ADAT, 32'h0000_0000, 3'b000);
        pin_op(ADR_ASET, 32'h0000_0005, 3'b101);
        pin_op(ADR_ACLR, 32'h0000_0001, 3'b100);
        pin_op(ADR_ATGL, 32'h0000_0007, 3'b011);
        pin_op(ADR_ADAT, 32'h0000_0006, 3'b110);
        access(1'b0, 1'b1, ADR_ATGL, 32'h0000_0000);
        access(1'b0, 1'b1, ADR_ASET, 32'h0000_0000);
        rnd = lfsr(rnd);
        pad_in_i = {7'h00, rnd};
        idle(4);
        access(1'b0, 1'b1, ADR_ADAT, rnd);
        $display("data test done");
        // pin 6 walks through the three peripheral options
        periph_i.oe = '1;
        periph_i.out[0][6] = 1'b1;
        periph_i.out[2][6] = 1'b1;
        for (int k = 1; k < 4; k++)
        begin
            // pin 6 has no reserved codes
            access(1'b1, 1'b1, ADR_AMX1, {18'h0, k[1:0], 12'h000});
            check("mux_hold", {31'h0, pad_o.out[6]}, {31'h0, k == 2});
            idle(1);
            check("mux_hold", {31'h0, pad_o.out[6]}, {31'h0, k == 2});
            idle(1);
            check("mux_new", {31'h0, pad_o.out[6]}, {31'h0, k[0]});
        end
        $display("mux test done");
        {trst_i, tdo_i, tdo_oe_i} = 3'b111;
        pad_in_i[38:35] = 4'b1001;
        idle(5);
        check("dbg_on", {27'h0, pad_o.oe[37], pad_o.out[37], dbg_o.tck, dbg_o.tms, dbg_o.tdi},
              32'h0000_001D);
        trst_i = 1'b0;
        idle(5);
        check("dbg_off", {30'h0, pad_o.oe[37], dbg_o.tck}, 32'h0);
        $display("debug test done");
        access(1'b1, 1'b1, ADR_XI12, 32'h0000_0003);
        pad_in_i[3] = 1'b1;
        idle(6);
        check("irq_sel", {31'h0, ext_irq_o[0]}, 32'h1);
        access(1'b0, 1'b1, 16'h6FF0, 32'h0000_0000);
        $display("select test done");
        access(1'b1, 1'b1, ADR_LPM, 32'h0000_0008);
        idle(3);
        check("lpm_idle", {31'h0, lpm_wake_o}, 32'h0);
        pad_in_i[3] = 1'b0;
        idle(6);
        check("lpm_wake", {31'h0, lpm_wake_o}, 32'h1);
        pad_in_i[5] = 1'b0;
        access(1'b1, 1'b1, ADR_AQS1, 32'h0000_0400);
        idle(4);
        pad_in_i[5] = 1'b1;
        idle(1);
        pad_in_i[5] = 1'b0;
        idle(8);
        check("qual_glitch", {31'h0, periph_in_o[5]}, 32'h0);
        pad_in_i[5] = 1'b1;
        idle(8);
        check("qual_level", {31'h0, periph_in_o[5]}, 32'h1);
        $display("wake and qualifier test done");
        aio_in_i = rnd[15:0];
        access(1'b1, 1'b1, ADR_IODIR, 32'h0000_0003);
        access(1'b1, 1'b1, ADR_IOMX, 32'h0000_0008);
        access(1'b1, 1'b0, ADR_IOSET, 32'h0000_0003);
        idle(2);
        check("aio_out", {16'h0, aio_o.out}, 32'h0000_0003);
        check("aio_oe_ana", {aio_o.oe, aio_o.ana}, 32'h0001_0002);
        access(1'b0, 1'b1, ADR_IODAT, {16'h0, rnd[15:0]});
        access(1'b1, 1'b1, ADR_BPUD, 32'hFFFF_FFFF);
        access(1'b1, 1'b1, ADR_APUD, 32'h0000_0001);
        access(1'b0, 1'b1, ADR_BPUD, 32'h0000_007F);
        check("pud", {pad_o.pud[38:32], pad_o.pud[24:0]}, 32'hFE00_0001);
        idle(2);
        check("queue", exp_q.size(), 32'h0);
        $display("analog and pull-up test done");
        complete_run();
    end
endmodule
